//--- obgc_consts.svh
// Constants for the output, bridge and gain configuration bank.
// Included by the bank module; definitions only.
`ifndef OBGC_CONSTS_SVH
`define OBGC_CONSTS_SVH

// ****************************************
// Register map: page and offsets (indices)
// ****************************************
`define OBGC_PAGE 2'h2
`define OBGC_OFS_DAC_MODE 8'h39
`define OBGC_OFS_OP_STAGE 8'h3b
`define OBGC_OFS_BRIDGE 8'h46
`define OBGC_OFS_PGAIN 8'h47
`define OBGC_IDX_W 10

// Non-volatile backing locations
`define OBGC_EE_DAC_MODE 32'h40000032
`define OBGC_EE_OP_STAGE 32'h40000033
`define OBGC_EE_BRIDGE 32'h40000034
`define OBGC_EE_PGAIN 32'h40000035

// ****************************************
// Reset values and writable-bit masks
// ****************************************
`define OBGC_RST_DAC_MODE 8'h00
`define OBGC_RST_OP_STAGE 8'h01
`define OBGC_RST_BRIDGE 8'h00
`define OBGC_RST_PGAIN 8'h00
`define OBGC_MSK_DAC_MODE 8'h01
`define OBGC_MSK_OP_STAGE 8'h3f
`define OBGC_MSK_BRIDGE 8'h07
`define OBGC_MSK_PGAIN 8'h9f

// ****************************************
// Field positions
// ****************************************
`define OBGC_BIT_RATIO 0
`define OBGC_FLD_GAIN 2:0
`define OBGC_BIT_LOOP 3
`define OBGC_BIT_CAP 4
`define OBGC_BIT_PULLUP 5
`define OBGC_BIT_BRIDGE_EN 0
`define OBGC_FLD_LEVEL 2:1
`define OBGC_FLD_PGAIN 4:0
`define OBGC_BIT_PINV 7

`endif

//--- obgc_pkg.sv
// Types for the output, bridge and gain configuration bank.
// Needs no other file.
package obgc_pkg;

    // Output stage voltage gain codes
    typedef enum logic [2:0] {
        GAIN_OFF = 3'b000,
        GAIN_10 = 3'b001,
        GAIN_4 = 3'b010,
        GAIN_2 = 3'b100,
        GAIN_6P67 = 3'b110
    } out_gain_t;

    // Bridge excitation levels
    typedef enum logic [1:0] {
        LVL_2V5 = 2'b00,
        LVL_2V0 = 2'b01,
        LVL_1V25 = 2'b10
    } bridge_level_t;

    // Register selected by a bus access
    typedef enum logic [1:0] {
        SEL_DAC = 2'b00,
        SEL_OPST = 2'b01,
        SEL_BRDG = 2'b10,
        SEL_PGAIN = 2'b11
    } reg_sel_t;

endpackage

//--- output_bridge_gain_config.sv
// Four 8-bit analog configuration registers behind an AHB-Lite slave.
// Assumes one clock, synchronous inputs, obgc_consts.svh and obgc_pkg.
`timescale 1ns/1ps
`include "obgc_consts.svh"

// Notes on behaviour
// - Four registers at page-two offsets, reset to fixed values
// - Bit0 chooses ratiometric or absolute DAC reference
// - Three-bit gain code selects voltage-mode gain
// - Bit3 closes current-loop switch
// - Bit4 closes output capacitor switch
// - Bit5 closes input pull-up switch
// - Bit0 enables bridge excitation supply
// - Bits2:1 select bridge supply level
// - Five-bit pressure gain code to front end
// - Bit7 inverts pressure gain output
module output_bridge_gain_config #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [DATA_W-1:0] hwdata,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic dac_ratiometric,
    output obgc_pkg::out_gain_t output_gain,
    output logic voltage_mode_enable,
    output logic gain_reserved,
    output logic loop_switch,
    output logic cap_switch,
    output logic pullup_switch,
    output logic bridge_supply_enable,
    output obgc_pkg::bridge_level_t bridge_level_select,
    output logic [4:0] pressure_gain_code,
    output logic pressure_output_invert
);

    // ****************************************
    // Helpers
    // ****************************************

    // Keep only writable bits of a byte
    function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
        masked = d & m;
    endfunction

    // Word index of a register: page bits above the offset
    function automatic logic [`OBGC_IDX_W-1:0] reg_idx(input logic [7:0] ofs);
        reg_idx = {`OBGC_PAGE, ofs};
    endfunction

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] dac_mode_config;
    logic [7:0] output_stage_control;
    logic [7:0] bridge_supply_control;
    logic [7:0] pressure_gain_select;

    // Data-phase state of the accepted transfer
    logic dp_act;
    logic dp_write;
    obgc_pkg::reg_sel_t dp_sel;

    // ****************************************
    // Address decode
    // ****************************************
    wire [`OBGC_IDX_W-1:0] aidx = haddr[`OBGC_IDX_W+1:2];
    wire upper_zero = (haddr[ADDR_W-1:`OBGC_IDX_W+2] == '0);
    wire hit_dac = upper_zero && (aidx == reg_idx(`OBGC_OFS_DAC_MODE));
    wire hit_opst = upper_zero && (aidx == reg_idx(`OBGC_OFS_OP_STAGE));
    wire hit_brdg = upper_zero && (aidx == reg_idx(`OBGC_OFS_BRIDGE));
    wire hit_pgain = upper_zero && (aidx == reg_idx(`OBGC_OFS_PGAIN));
    wire hit_any = hit_dac | hit_opst | hit_brdg | hit_pgain;
    wire take = hsel && hready && htrans[1];
    wire take_hit = take && hit_any;
    wire obgc_pkg::reg_sel_t asel = hit_dac ? obgc_pkg::SEL_DAC :
                                    hit_opst ? obgc_pkg::SEL_OPST :
                                    hit_brdg ? obgc_pkg::SEL_BRDG :
                                    obgc_pkg::SEL_PGAIN;

    // ****************************************
    // Write strobes in the data phase
    // ****************************************
    wire wr_fire = ce && dp_act && dp_write;
    wire wr_dac = wr_fire && (dp_sel == obgc_pkg::SEL_DAC);
    wire wr_opst = wr_fire && (dp_sel == obgc_pkg::SEL_OPST);
    wire wr_brdg = wr_fire && (dp_sel == obgc_pkg::SEL_BRDG);
    wire wr_pgain = wr_fire && (dp_sel == obgc_pkg::SEL_PGAIN);
    wire [7:0] wbyte = hwdata[7:0];

    // ****************************************
    // Read mux
    // ****************************************
    wire [7:0] rd_byte = (asel == obgc_pkg::SEL_DAC) ? dac_mode_config :
                         (asel == obgc_pkg::SEL_OPST) ? output_stage_control :
                         (asel == obgc_pkg::SEL_BRDG) ? bridge_supply_control :
                         pressure_gain_select;
    wire [DATA_W-1:0] next_hrdata = (take_hit && !hwrite) ?
                                    {{(DATA_W-8){1'b0}}, rd_byte} : '0;

    // ****************************************
    // Decoded control levels
    // ****************************************
    wire [2:0] gcode = output_stage_control[`OBGC_FLD_GAIN];
    wire next_gain_ok = (gcode == obgc_pkg::GAIN_10) || (gcode == obgc_pkg::GAIN_4) ||
                        (gcode == obgc_pkg::GAIN_2) || (gcode == obgc_pkg::GAIN_6P67);
    wire next_gain_res = !next_gain_ok && (gcode != obgc_pkg::GAIN_OFF);
    wire [1:0] lvl = bridge_supply_control[`OBGC_FLD_LEVEL];
    wire obgc_pkg::bridge_level_t next_level = lvl[1] ? obgc_pkg::LVL_1V25 :
                                               lvl[0] ? obgc_pkg::LVL_2V0 :
                                               obgc_pkg::LVL_2V5;

    // Bus phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_act <= 1'b0;
            dp_write <= 1'b0;
            dp_sel <= obgc_pkg::SEL_DAC;
        end else if (ce) begin
            dp_act <= take_hit;
            dp_write <= hwrite;
            dp_sel <= asel;
        end
    end

    // Bus answers: zero wait, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Register writes, masked to defined fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_mode_config <= `OBGC_RST_DAC_MODE;
            output_stage_control <= `OBGC_RST_OP_STAGE;
            bridge_supply_control <= `OBGC_RST_BRIDGE;
            pressure_gain_select <= `OBGC_RST_PGAIN;
        end else begin
            if (wr_dac) begin
                dac_mode_config <= masked(wbyte, `OBGC_MSK_DAC_MODE);
            end
            if (wr_opst) begin
                output_stage_control <= masked(wbyte, `OBGC_MSK_OP_STAGE);
            end
            if (wr_brdg) begin
                bridge_supply_control <= masked(wbyte, `OBGC_MSK_BRIDGE);
            end
            if (wr_pgain) begin
                pressure_gain_select <= masked(wbyte, `OBGC_MSK_PGAIN);
            end
        end
    end

    // Analog control outputs, one flop after the registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_ratiometric <= 1'b0;
            output_gain <= obgc_pkg::GAIN_10;
            voltage_mode_enable <= 1'b1;
            gain_reserved <= 1'b0;
            loop_switch <= 1'b0;
            cap_switch <= 1'b0;
            pullup_switch <= 1'b0;
            bridge_supply_enable <= 1'b0;
            bridge_level_select <= obgc_pkg::LVL_2V5;
            pressure_gain_code <= 5'h00;
            pressure_output_invert <= 1'b0;
        end else if (ce) begin
            dac_ratiometric <= dac_mode_config[`OBGC_BIT_RATIO];
            output_gain <= obgc_pkg::out_gain_t'(gcode);
            voltage_mode_enable <= next_gain_ok;
            gain_reserved <= next_gain_res;
            loop_switch <= output_stage_control[`OBGC_BIT_LOOP];
            cap_switch <= output_stage_control[`OBGC_BIT_CAP];
            pullup_switch <= output_stage_control[`OBGC_BIT_PULLUP];
            bridge_supply_enable <= bridge_supply_control[`OBGC_BIT_BRIDGE_EN];
            bridge_level_select <= next_level;
            pressure_gain_code <= pressure_gain_select[`OBGC_FLD_PGAIN];
            pressure_output_invert <= pressure_gain_select[`OBGC_BIT_PINV];
        end
    end

    // ****************************************
    // Checks
    // ****************************************

    // Read of the output stage register returns it
    AST_MAP_READ: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && take && hit_opst && !hwrite) |=> (hrdata[7:0] == $past(output_stage_control))
    ) else $error("output stage readback wrong");

    // Written reference mode reaches the DAC two edges on
    AST_RATIO: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_dac ##1 ce) |=> (dac_ratiometric == $past(hwdata[0], 2))
    ) else $error("ratiometric mode not applied");

    // Voltage mode only for listed gain codes
    AST_GAIN_DECODE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce |=> (voltage_mode_enable == ($past(gcode) inside {3'b001, 3'b010, 3'b100, 3'b110}))
              && (gain_reserved == ($past(gcode) inside {3'b011, 3'b101, 3'b111}))
    ) else $error("gain decode wrong");

    // Loop switch follows written bit
    AST_LOOP: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_opst ##1 ce) |=> (loop_switch == $past(hwdata[3], 2))
    ) else $error("loop switch not applied");

    // Capacitor switch tracks its bit
    AST_CAP: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce |=> (cap_switch == $past(output_stage_control[4]))
    ) else $error("cap switch mismatch");

    // Pull-up switch follows written bit
    AST_PULLUP: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_opst ##1 ce) |=> (pullup_switch == $past(hwdata[5], 2))
    ) else $error("pull-up switch not applied");

    // Bridge enable follows written bit
    AST_BRIDGE_EN: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_brdg ##1 ce) |=> (bridge_supply_enable == $past(hwdata[0], 2))
    ) else $error("bridge enable not applied");

    // Upper level bit always gives the lowest level
    AST_LEVEL: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && bridge_supply_control[2]) |=> (bridge_level_select == obgc_pkg::LVL_1V25)
    ) else $error("bridge level decode wrong");

    // Pressure gain code passed through
    AST_PGAIN: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_pgain ##1 ce) |=> (pressure_gain_code == $past(hwdata[4:0], 2))
    ) else $error("pressure gain not applied");

    // Inversion follows its bit
    AST_PINV: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce |=> (pressure_output_invert == $past(pressure_gain_select[7]))
    ) else $error("pressure invert mismatch");

    // Unused bits stay zero
    AST_UNUSED_ZERO: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (hrdata[DATA_W-1:8] == '0) && (output_stage_control[7:6] == 2'b00)
        && (pressure_gain_select[6:5] == 2'b00) && (bridge_supply_control[7:3] == 5'h00)
        && (dac_mode_config[7:1] == 7'h00)
    ) else $error("unused bits not zero");

    // Reset leaves gain at the 10 V/V code, switches and bridge enable off
    AST_RESET_VAL: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> (output_stage_control == 8'h01) && (bridge_supply_control == 8'h00)
    ) else $error("reset values wrong");

    // Output stage write keeps only its defined bits
    AST_OPST_WRITE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_opst |=> (output_stage_control == $past(hwdata[7:0] & `OBGC_MSK_OP_STAGE))
    ) else $error("output stage write not masked");

    // Pressure gain write keeps only its defined bits
    AST_PGAIN_WRITE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pgain |=> (pressure_gain_select == $past(hwdata[7:0] & `OBGC_MSK_PGAIN))
    ) else $error("pressure gain write not masked");

    // No mapped read taken means zero read data
    AST_RD_IDLE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && !(take_hit && !hwrite)) |=> (hrdata == '0)
    ) else $error("read data not zero");

    // Low enable holds register and switch levels
    AST_CE_FREEZE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !ce |=> $stable(output_stage_control) && $stable(loop_switch) && $stable(cap_switch)
              && $stable(pullup_switch) && $stable(hrdata)
    ) else $error("state moved with enable low");

    // Level code zero gives the highest bridge level
    AST_LEVEL_TOP: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && (bridge_supply_control[2:1] == 2'b00)) |=> (bridge_level_select == obgc_pkg::LVL_2V5)
    ) else $error("bridge top level decode wrong");

endmodule

//--- test_output_bridge_gain_config.sv
// Self-checking bench for the output, bridge and gain configuration bank.
// Assumes obgc_pkg compiled first and obgc_consts.svh on the include path.
`timescale 1ns/1ps
`include "obgc_consts.svh"

module test_output_bridge_gain_config;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic ce = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic dac_ratiometric;
    obgc_pkg::out_gain_t output_gain;
    logic voltage_mode_enable;
    logic gain_reserved;
    logic loop_switch;
    logic cap_switch;
    logic pullup_switch;
    logic bridge_supply_enable;
    obgc_pkg::bridge_level_t bridge_level_select;
    logic [4:0] pressure_gain_code;
    logic pressure_output_invert;
    int failures = 0;
    int total_checks = 0;
    logic [31:0] rd;

    output_bridge_gain_config u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dac_ratiometric(dac_ratiometric), .output_gain(output_gain),
        .voltage_mode_enable(voltage_mode_enable), .gain_reserved(gain_reserved),
        .loop_switch(loop_switch), .cap_switch(cap_switch), .pullup_switch(pullup_switch),
        .bridge_supply_enable(bridge_supply_enable), .bridge_level_select(bridge_level_select),
        .pressure_gain_code(pressure_gain_code),
        .pressure_output_invert(pressure_output_invert));

    // Free-running 10 MHz clock
    always #50 hclk = ~hclk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic give_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Byte address of a page-two offset
    function automatic logic [31:0] reg_addr(input logic [7:0] ofs);
        return {20'h0, `OBGC_PAGE, ofs, 2'h0};
    endfunction

    // Bounded wait for an edge with hready high
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (n >= 50) begin
            failures++;
            give_verdict();
        end
    endtask

    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        wait_ready();
        r = hrdata;
    endtask

    // Write, then let the analog outputs follow
    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] r;
        bus(reg_addr(ofs), 1'h1, d, r);
        repeat (2) @(posedge hclk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        bus(reg_addr(ofs), 1'h0, 32'h0, rd);
        check(rd, {24'h0, exp});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic reset_values();
        #1;
        check(32'(output_gain), 32'h1);
        check(32'({voltage_mode_enable, dac_ratiometric, loop_switch, cap_switch}), 32'h8);
        check(32'({pullup_switch, bridge_supply_enable, pressure_output_invert}), 32'h0);
        check(32'({bridge_level_select, pressure_gain_code}), 32'h0);
        check(32'({hreadyout, hresp}), 32'h2);
        rd_chk(`OBGC_OFS_DAC_MODE, `OBGC_RST_DAC_MODE);
        rd_chk(`OBGC_OFS_OP_STAGE, `OBGC_RST_OP_STAGE);
        rd_chk(`OBGC_OFS_BRIDGE, `OBGC_RST_BRIDGE);
        rd_chk(`OBGC_OFS_PGAIN, `OBGC_RST_PGAIN);
    endtask

    task automatic map_and_masks();
        logic [31:0] r;
        wr(`OBGC_OFS_DAC_MODE, 32'hffff_ff01);
        wr(`OBGC_OFS_OP_STAGE, 32'h2a);
        wr(`OBGC_OFS_BRIDGE, 32'h05);
        wr(`OBGC_OFS_PGAIN, 32'h93);
        rd_chk(`OBGC_OFS_DAC_MODE, 8'h01);
        rd_chk(`OBGC_OFS_OP_STAGE, 8'h2a);
        rd_chk(`OBGC_OFS_BRIDGE, 8'h05);
        rd_chk(`OBGC_OFS_PGAIN, 8'h93);
        // Unmapped neighbour: write dropped, reads zero
        bus(reg_addr(8'h3a), 1'h1, 32'hff, r);
        bus(reg_addr(8'h3a), 1'h0, 32'h0, rd);
        check(rd, 32'h0);
        check(32'(hresp), 32'h0);
        rd_chk(`OBGC_OFS_OP_STAGE, 8'h2a);
        // All-ones writes keep only the defined bits
        wr(`OBGC_OFS_DAC_MODE, 32'hff);
        wr(`OBGC_OFS_OP_STAGE, 32'hff);
        wr(`OBGC_OFS_BRIDGE, 32'hff);
        wr(`OBGC_OFS_PGAIN, 32'hff);
        rd_chk(`OBGC_OFS_DAC_MODE, 8'h01);
        rd_chk(`OBGC_OFS_OP_STAGE, 8'h3f);
        rd_chk(`OBGC_OFS_BRIDGE, 8'h07);
        rd_chk(`OBGC_OFS_PGAIN, 8'h9f);
        check(32'({pressure_output_invert, pressure_gain_code}), 32'h3f);
    endtask

    task automatic dac_and_gain();
        logic [2:0] c;
        wr(`OBGC_OFS_DAC_MODE, 32'h1);
        check(32'(dac_ratiometric), 32'h1);
        wr(`OBGC_OFS_DAC_MODE, 32'h0);
        check(32'(dac_ratiometric), 32'h0);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(`OBGC_OFS_OP_STAGE, {29'h0, c});
            check(32'(output_gain), 32'(c));
            check(32'(voltage_mode_enable), 32'(c inside {3'h1, 3'h2, 3'h4, 3'h6}));
            check(32'(gain_reserved), 32'(c inside {3'h3, 3'h5, 3'h7}));
        end
    endtask

    task automatic switches();
        for (int i = 0; i < 3; i++) begin
            wr(`OBGC_OFS_OP_STAGE, 32'h8 << i);
            check(32'(loop_switch), 32'(i == 0));
            check(32'(cap_switch), 32'(i == 1));
            check(32'(pullup_switch), 32'(i == 2));
        end
    endtask

    task automatic bridge_and_pgain();
        for (int i = 0; i < 4; i++) begin
            wr(`OBGC_OFS_BRIDGE, 32'(i * 2 + (i % 2)));
            check(32'(bridge_supply_enable), 32'(i % 2));
            check(32'(bridge_level_select), 32'((i > 2) ? 2 : i));
        end
        wr(`OBGC_OFS_PGAIN, 32'h75);
        check(32'(pressure_gain_code), 32'h15);
        check(32'(pressure_output_invert), 32'h0);
        wr(`OBGC_OFS_PGAIN, 32'h8a);
        check(32'(pressure_gain_code), 32'h0a);
        check(32'(pressure_output_invert), 32'h1);
    endtask

    // Enable low holds the switches until it returns
    task automatic ce_freeze();
        logic [31:0] r;
        wr(`OBGC_OFS_OP_STAGE, 32'h10);
        bus(reg_addr(`OBGC_OFS_OP_STAGE), 1'h1, 32'h08, r);
        ce <= 1'h0;
        repeat (4) @(posedge hclk);
        #1;
        check(32'({loop_switch, cap_switch}), 32'h1);
        @(posedge hclk);
        ce <= 1'h1;
        repeat (2) @(posedge hclk);
        #1;
        check(32'({loop_switch, cap_switch}), 32'h2);
        rd_chk(`OBGC_OFS_OP_STAGE, 8'h08);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        reset_values();
        map_and_masks();
        dac_and_gain();
        switches();
        bridge_and_pgain();
        ce_freeze();
        give_verdict();
    end
endmodule
